// ---- adc_serial_pkg.sv ----
`default_nettype none
package adc_serial_pkg;

  // result and configuration word sizes
  localparam int RESULT_BITS = 12;
  localparam int CONFIG_BITS = 4;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;

  // control register fields and reset value
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // status register fields
  localparam int STAT_STATE_LSB    = 0;
  localparam int STAT_CFG_LSB      = 4;
  localparam int STAT_SHUTDOWN_BIT = 8;
  localparam int STAT_VALID_BIT    = 9;
  localparam int STAT_DRIVE_BIT    = 10;

  // result register fields
  localparam int RESULT_DATA_LSB  = 0;
  localparam int RESULT_VALID_BIT = 16;

  // configuration word bit positions after shifting in
  localparam int CFG_SGL_BIT  = 3;
  localparam int CFG_ODD_BIT  = 2;
  localparam int CFG_MSB_FIRST_ONLY_BIT = 1;
  localparam int CFG_PS_N_BIT = 0;

  // output slot numbering, counted in falling shift-clock edges
  localparam logic [4:0] SLOT_NULL     = 5'h00;
  localparam logic [4:0] SLOT_LAST_MSB = 5'h0C;
  localparam logic [4:0] SLOT_LAST_LSB = 5'h17;
  localparam logic [4:0] SLOT_MAX      = 5'h1F;

  // first successive-approximation trial code
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

  // serial link state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HUNT,
    ST_CONFIG,
    ST_CONVERT
  } link_state_t;

  // controls toward the analog front end
  typedef struct packed {
    logic        single_ended_select;
    logic        pos_is_input_b;
    logic        hold;
    logic        power_down;
    logic [11:0] dac_code;
  } analog_ctrl_t;

endpackage
`default_nettype wire

// ---- adc_serial_control_interface.sv ----
`default_nettype none
// Summary of operation
// - launch output bits on falling shift edge, sample inputs on rising edge
// - half duplex: receive configuration first, drive result afterwards
// - falling select starts a transaction and start-bit hunting
// - first one sampled after select falls is the start bit
// - four configuration bits follow start bit and launch the conversion
// - further serial input ignored until select is raised and lowered
// - one null bit, then result MSB first as each step decides
// - high select returns the interface to idle
// - mode and polarity bits pick channel pair or channel against ground
// - single-ended measures against ground; only positive side is held
// - bit-order one: MSB first then zeros while clocking continues
// - bit-order zero: MSB first then LSB first sharing the LSB
// - power-control bit zero enters shutdown instead of converting
// - shutdown: twelve ones then zeros; output released when select rises
// - shutdown lasts only until the next select cycle, no warm-up
// - result is 12-bit unipolar straight binary
// - serial interface enabled only while select is low
module adc_serial_control_interface (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        select_n_i,
  input  wire logic                        shift_clk_i,
  input  wire logic                        serial_in_i,
  output logic                             serial_out_o,
  output logic                             serial_oe_o,
  input  wire logic                        comp_i,
  output adc_serial_pkg::analog_ctrl_t     analog_o
);

  // pin synchronisers; element 0 is only read by element 1
  logic [1:0]  sel_sync_q;
  logic [2:0]  sclk_sync_q;
  logic [1:0]  din_sync_q;
  logic [1:0]  comp_sync_q;

  // register file
  logic        enable_q;
  logic        ack_q;
  logic [31:0] rd_q;

  // link state
  adc_serial_pkg::link_state_t state_q;
  logic [1:0]  cfg_cnt_q;
  logic [3:0]  cfg_q;
  logic [4:0]  slot_q;
  logic [11:0] trial_q;
  logic [11:0] result_q;
  logic        valid_q;
  logic        shutdown_q;
  logic        hold_q;
  logic        dout_q;
  logic        oe_q;

  // one successive-approximation step on bit idx
  function automatic logic [11:0] sar_step(input logic [11:0] code, input logic [3:0] idx, input logic keep);
    logic [11:0] next;
    next      = code;
    next[idx] = keep;
    if (idx != 4'h0) begin
      next[idx - 4'h1] = 1'b1;
    end
    return next;
  endfunction

  // sampling of pins into the clk_i domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_sync_q  <= 2'h3;
      sclk_sync_q <= 3'h0;
      din_sync_q  <= 2'h0;
      comp_sync_q <= 2'h0;
    end else begin
      sel_sync_q  <= {sel_sync_q[0], select_n_i};
      sclk_sync_q <= {sclk_sync_q[1:0], shift_clk_i};
      din_sync_q  <= {din_sync_q[0], serial_in_i};
      comp_sync_q <= {comp_sync_q[0], comp_i};
    end
  end

  // edge and level decode of the synchronised pins
  wire link_active = ~sel_sync_q[1] & enable_q;
  wire sclk_rise   = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire sclk_fall   = ~sclk_sync_q[1] & sclk_sync_q[2];
  wire din_s       = din_sync_q[1];
  wire comp_s      = comp_sync_q[1];

  // output slot decode
  wire        msb_first_only = cfg_q[adc_serial_pkg::CFG_MSB_FIRST_ONLY_BIT];
  wire        in_msb_phase   = (slot_q != adc_serial_pkg::SLOT_NULL) && (slot_q <= adc_serial_pkg::SLOT_LAST_MSB);
  wire        in_lsb_phase   = (slot_q > adc_serial_pkg::SLOT_LAST_MSB) && (slot_q <= adc_serial_pkg::SLOT_LAST_LSB);
  wire [3:0]  msb_idx        = 4'(adc_serial_pkg::SLOT_LAST_MSB - slot_q);
  wire [3:0]  lsb_idx        = 4'(slot_q - adc_serial_pkg::SLOT_LAST_MSB);
  wire [4:0]  slot_next      = (slot_q == adc_serial_pkg::SLOT_MAX) ? slot_q : slot_q + 5'h01;
  wire [11:0] trial_next     = (slot_q == adc_serial_pkg::SLOT_NULL) ? adc_serial_pkg::SAR_FIRST_TRIAL
                                                                    : sar_step(trial_q, msb_idx, comp_s);

  // bit for the next falling edge
  logic out_bit;
  always_comb begin
    out_bit = 1'b0;
    if (shutdown_q) begin
      out_bit = in_msb_phase;
    end else if (in_msb_phase) begin
      out_bit = comp_s;
    end else if (in_lsb_phase && !msb_first_only) begin
      out_bit = result_q[lsb_idx];
    end
  end

  // serial link sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= adc_serial_pkg::ST_IDLE;
      cfg_cnt_q  <= 2'h0;
      cfg_q      <= 4'h0;
      slot_q     <= 5'h00;
      trial_q    <= 12'h000;
      result_q   <= 12'h000;
      valid_q    <= 1'b0;
      shutdown_q <= 1'b0;
      hold_q     <= 1'b0;
      dout_q     <= 1'b0;
      oe_q       <= 1'b0;
    end else if (!link_active) begin
      state_q   <= adc_serial_pkg::ST_IDLE;
      cfg_cnt_q <= 2'h0;
      slot_q    <= 5'h00;
      hold_q    <= 1'b0;
      dout_q    <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      case (state_q)
        adc_serial_pkg::ST_IDLE: begin
          state_q    <= adc_serial_pkg::ST_HUNT;
          shutdown_q <= 1'b0;
        end
        adc_serial_pkg::ST_HUNT: begin
          if (sclk_rise && din_s) begin
            state_q <= adc_serial_pkg::ST_CONFIG;
          end
        end
        adc_serial_pkg::ST_CONFIG: begin
          if (sclk_rise) begin
            cfg_q     <= {cfg_q[2:0], din_s};
            cfg_cnt_q <= cfg_cnt_q + 2'h1;
            if (cfg_cnt_q == 2'(adc_serial_pkg::CONFIG_BITS - 1)) begin
              state_q    <= adc_serial_pkg::ST_CONVERT;
              valid_q    <= 1'b0;
              shutdown_q <= ~din_s;
              hold_q     <= din_s;
              slot_q     <= adc_serial_pkg::SLOT_NULL;
            end
          end
        end
        adc_serial_pkg::ST_CONVERT: begin
          if (sclk_fall) begin
            slot_q <= slot_next;
            oe_q   <= 1'b1;
            dout_q <= out_bit;
            if (!shutdown_q && (slot_q <= adc_serial_pkg::SLOT_LAST_MSB)) begin
              trial_q <= trial_next;
            end
            if (!shutdown_q && (slot_q == adc_serial_pkg::SLOT_LAST_MSB)) begin
              result_q <= trial_next;
              valid_q  <= 1'b1;
              hold_q   <= 1'b0;
            end
          end
        end
        default: begin
          state_q <= adc_serial_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // pins and analog front-end controls
  // undriven before null bit
  assign serial_out_o = dout_q;
  assign serial_oe_o  = oe_q;
  assign analog_o.single_ended_select = cfg_q[adc_serial_pkg::CFG_SGL_BIT];
  assign analog_o.pos_is_input_b      = cfg_q[adc_serial_pkg::CFG_ODD_BIT];
  assign analog_o.hold                = hold_q;
  assign analog_o.power_down          = shutdown_q;
  assign analog_o.dac_code            = trial_q;

  // register bus decode
  wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire hit_ctrl  = (wb_adr_i == adc_serial_pkg::CTRL_OFFSET);
  wire hit_stat  = (wb_adr_i == adc_serial_pkg::STATUS_OFFSET);
  wire hit_res   = (wb_adr_i == adc_serial_pkg::RESULT_OFFSET);
  wire ctrl_wr   = bus_req & wb_we_i & hit_ctrl & wb_sel_i[0];

  // read data selection, unmapped reads as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[adc_serial_pkg::CTRL_ENABLE_BIT] = enable_q;
    end else if (hit_stat) begin
      rd_mux[adc_serial_pkg::STAT_STATE_LSB +: 2] = state_q;
      rd_mux[adc_serial_pkg::STAT_CFG_LSB +: 4]   = cfg_q;
      rd_mux[adc_serial_pkg::STAT_SHUTDOWN_BIT]   = shutdown_q;
      rd_mux[adc_serial_pkg::STAT_VALID_BIT]      = valid_q;
      rd_mux[adc_serial_pkg::STAT_DRIVE_BIT]      = oe_q;
    end else if (hit_res) begin
      rd_mux[adc_serial_pkg::RESULT_DATA_LSB +: 12] = result_q;
      rd_mux[adc_serial_pkg::RESULT_VALID_BIT]      = valid_q;
    end
  end

  // wishbone slave: one wait state, every address acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      rd_q     <= 32'h0000_0000;
      enable_q <= adc_serial_pkg::CTRL_RESET[adc_serial_pkg::CTRL_ENABLE_BIT];
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        rd_q <= rd_mux;
      end
      if (ctrl_wr) begin
        enable_q <= wb_dat_i[adc_serial_pkg::CTRL_ENABLE_BIT];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

endmodule
`default_nettype wire

// ---- adc_serial_control_interface_checker.sv ----
`default_nettype none
module adc_serial_checker (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_ack_o,
  input wire logic                         select_n_i,
  input wire logic                         shift_clk_i,
  input wire logic                         serial_out_o,
  input wire logic                         serial_oe_o,
  input wire adc_serial_pkg::analog_ctrl_t analog_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // select high long enough to pass the synchroniser
  sequence s_deselected;
    select_n_i [*6];
  endsequence
  // bus request still waiting for its answer
  sequence s_request;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // output enable rising while a conversion holds its sample
  sequence s_trial_start;
    $rose(serial_oe_o) && analog_o.hold;
  endsequence
  // output bit changing well inside a select-low frame
  sequence s_frame_change;
    !select_n_i && !$past(select_n_i, 4) && $changed(serial_out_o);
  endsequence
  // first trial code present when driving starts
  property p_first_trial;
    s_trial_start |-> analog_o.dac_code == adc_serial_pkg::SAR_FIRST_TRIAL;
  endproperty
  // driving starts just after a falling shift edge
  property p_drive_late;
    $rose(serial_oe_o) |-> !shift_clk_i && $past(shift_clk_i, 6);
  endproperty
  a_ack_one_wait: assert property (s_request |=> wb_ack_o)
    else $error("ack not after one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_idle_released: assert property (s_deselected |-> !serial_oe_o)
    else $error("output driven while idle");
  a_idle_no_hold: assert property (s_deselected |-> !analog_o.hold)
    else $error("hold while idle");
  a_null_first: assert property ($rose(serial_oe_o) |-> !serial_out_o)
    else $error("first bit not null");
  a_first_trial: assert property (p_first_trial)
    else $error("bad first trial code");
  a_launch_falling: assert property (s_frame_change |-> !shift_clk_i)
    else $error("output changed with shift clock high");
  a_drive_late: assert property (p_drive_late)
    else $error("drive not at a falling edge");
  a_shutdown_idle: assert property (analog_o.power_down |-> !analog_o.hold)
    else $error("hold in shutdown");
  a_wake_prompt: assert property ($fell(select_n_i) |-> ##[1:5] !analog_o.power_down)
    else $error("shutdown kept after select fell");
endmodule
bind adc_serial_control_interface adc_serial_checker u_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .select_n_i(select_n_i),
  .shift_clk_i(shift_clk_i), .serial_out_o(serial_out_o), .serial_oe_o(serial_oe_o), .analog_o(analog_o));
`default_nettype wire

// ---- serial_host_model.sv ----
`default_nettype none
module serial_host (
  input  wire logic clk_i,
  input  wire logic data_i,
  output var logic  select_n_o,
  output var logic  shift_clk_o,
  output var logic  din_o,
  output var logic  drive_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, shift clock parked low
  initial begin
    select_n_o = 1'b1;
    shift_clk_o = 1'b0;
    din_o = 1'b0;
    drive_o = 1'b0;
  end
  // launch while low, sample at rise
  task automatic bit_cycle(input logic b, output logic s);
    din_o <= b;
    repeat (10) @(posedge clk_i);
    shift_clk_o <= 1'b1;
    s = data_i;
    repeat (10) @(posedge clk_i);
    shift_clk_o <= 1'b0;
  endtask
  task automatic xfer(input logic [3:0] cfg, input int zeros, output logic [25:0] got);
    logic s;
    select_n_o <= 1'b0;
    drive_o <= 1'b1;
    repeat (zeros) bit_cycle(1'b0, s);
    bit_cycle(1'b1, s);
    for (int i = 3; i >= 0; i--) bit_cycle(cfg[i], s);
    // let go of the shared wire
    drive_o <= 1'b0;
    for (int i = 25; i >= 0; i--) begin
      bit_cycle(~din_o, s);
      got[i] = s;
    end
    repeat (10) @(posedge clk_i);
    select_n_o <= 1'b1;
    repeat (20) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- adc_serial_control_interface_test.sv ----
`default_nettype none
module adc_serial_control_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clk_i = 1'b0;
  logic                         rst_i = 1'b1;
  logic                         cyc = 1'b0;
  logic                         stb = 1'b0;
  logic                         we = 1'b0;
  logic [7:0]                   adr = 8'h00;
  logic [31:0]                  wdat = 32'h0000_0000;
  logic [11:0]                  vin = 12'h000;
  logic [1:0]                   mux_seen = 2'h0;
  logic [31:0]                  rdat;
  logic                         ack, sel_n, sclk, din, drive, dout, oe;
  adc_serial_pkg::analog_ctrl_t ana;
  int                           n_mismatch = 0;
  int                           tests_run = 0;
  int                           cycles = 0;
  wire logic                    data_w;
  // shared wire: device, host, else a toggling floating level
  assign data_w = oe ? dout : (drive ? din : ~din);
  adc_serial_control_interface DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .select_n_i(sel_n),
    .shift_clk_i(sclk), .serial_in_i(data_w), .serial_out_o(dout), .serial_oe_o(oe),
    .comp_i(vin >= ana.dac_code), .analog_o(ana));
  serial_host host (.clk_i(clk_i), .data_i(data_w), .select_n_o(sel_n), .shift_clk_o(sclk), .din_o(din),
    .drive_o(drive));
  initial forever #25 clk_i = ~clk_i;
  // channel routing seen while the sample is held
  always @(posedge clk_i) if (ana.hold === 1'b1) mux_seen <= {ana.single_ended_select, ana.pos_is_input_b};
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic conv(input logic [3:0] cfg, input logic [11:0] v);
    logic [25:0] got, e;
    logic [31:0] q;
    vin <= v;
    e = {1'b0, v, 13'h0000};
    if (!cfg[1]) for (int i = 1; i < 12; i++) e[13 - i] = v[i];
    host.xfer(cfg, 2, got);
    check("result bits", {6'h00, got}, {6'h00, e});
    check("mux", {30'h0000_0000, mux_seen}, {30'h0000_0000, cfg[3:2]});
    wb(1'b0, adc_serial_pkg::RESULT_OFFSET, 32'h0000_0000, q);
    check("result reg", q, {15'h0000, 1'b1, 4'h0, v});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic [25:0] got;
    wb(1'b0, adc_serial_pkg::CTRL_OFFSET, 32'h0000_0000, q);
    check("ctrl reset", q, adc_serial_pkg::CTRL_RESET);
    wb(1'b1, adc_serial_pkg::CTRL_OFFSET, 32'h0000_0000, q);
    wb(1'b0, adc_serial_pkg::CTRL_OFFSET, 32'h0000_0000, q);
    check("ctrl written", q, 32'h0000_0000);
    // a frame while disabled leaves the link untouched
    host.xfer(4'hB, 0, got);
    wb(1'b0, adc_serial_pkg::STATUS_OFFSET, 32'h0000_0000, q);
    check("disabled status", q, 32'h0000_0000);
    wb(1'b1, adc_serial_pkg::CTRL_OFFSET, 32'h0000_0001, q);
    wb(1'b0, 8'h0C, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
  endtask
  task automatic t_modes();
    conv(4'hB, 12'h000);
    conv(4'h9, 12'hFFF);
    for (int m = 0; m < 8; m++) conv({m[2:0], 1'b1}, 12'h9E3 ^ (12'h155 * m[2:0]));
  endtask
  task automatic t_shutdown();
    logic [25:0] got;
    logic [31:0] q;
    host.xfer(4'hE, 0, got);
    check("shutdown bits", {6'h00, got}, {6'h00, 1'b0, 12'hFFF, 13'h0000});
    check("power down", {31'h0000_0000, ana.power_down}, 32'h0000_0001);
    // idle, config kept despite later toggling, shutdown set, not valid, not driving
    wb(1'b0, adc_serial_pkg::STATUS_OFFSET, 32'h0000_0000, q);
    check("shutdown status", q, 32'h0000_01E0);
    conv(4'hF, 12'h7FF);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_modes();
    t_shutdown();
    results();
  end
endmodule
`default_nettype wire
